// *** rtl/crd_core.sv ***
// cordic coprocessor: apb registers, 26/21-bit iteration kernel and control
`default_nettype none
module crd_core
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // module clock gate
  input wire logic mod_clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // completion request and busy status
  output logic calc_done_irq,
  output logic calc_busy
);
  typedef struct packed {
    crd_pkg::crd_state_t st;
    logic [3:0] iter;
    logic [crd_pkg::XY_W-1:0] x;
    logic [crd_pkg::XY_W-1:0] y;
    logic [crd_pkg::Z_W-1:0] z;
    logic [15:0] xin;
    logic [15:0] yin;
    logic [15:0] zin;
    logic [1:0] mode;
    logic vec;
    logic keep;
    logic xuns;
    logic eoc;
    logic irq;
    logic [5:0] cnt;
    logic [31:0] rdata;
  } crd_regs_t;

  crd_regs_t r, n;

  logic [crd_pkg::TBL_W-1:0] tbl_q;
  logic [3:0] tbl_shift;
  logic [3:0] sh;
  logic acc;
  logic wr;
  logic start;
  logic mapped;
  logic half_turn;
  logic [15:0] x_view;

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode; every register sits on an aligned word
  function automatic logic crd_hit_f(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    crd_hit_f = (a == ADDR_W'(off));
  endfunction : crd_hit_f

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign mapped = crd_hit_f(paddr, crd_pkg::OFF_CTRL) || crd_hit_f(paddr, crd_pkg::OFF_STAT)
    || crd_hit_f(paddr, crd_pkg::OFF_X) || crd_hit_f(paddr, crd_pkg::OFF_Y)
    || crd_hit_f(paddr, crd_pkg::OFF_Z);
  // zero wait states: data was fetched in the setup cycle
  assign pready = acc;
  assign pslverr = acc && !mapped;
  assign prdata = r.rdata;
  assign calc_done_irq = r.irq;
  assign calc_busy = r.st != crd_pkg::ST_IDLE;

  // go taken only from idle; a go while busy is dropped
  assign start = wr && crd_hit_f(paddr, crd_pkg::OFF_CTRL) && pwdata[crd_pkg::CTRL_GO]
    && r.st == crd_pkg::ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////////
  // x result view: unsigned option clamps instead of wrapping
  always_comb
  begin
    x_view = r.x[23:8];
    if (r.xuns)
    begin
      if (r.x[crd_pkg::XY_W-1])
        x_view = 16'h0000;
      else if (r.x[24])
        x_view = 16'hFFFF;
      else
        x_view = r.x[23:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // circular iterations only converge within about a quarter turn, so operands in the
  // outer half are folded by a half turn first; linear and hyperbolic ranges are the
  // caller's concern and are left untouched
  assign half_turn = r.mode != crd_pkg::MODE_LIN && r.mode != crd_pkg::MODE_HYP
    && (r.vec ? r.x[crd_pkg::XY_W-1] : (r.z[19] ^ r.z[18]));

  ////////////////////////////////////////////////////////////////////////////////
  // table fetch runs one step ahead of the kernel
  assign sh = crd_pkg::crd_shift_f(r.mode, r.iter);
  assign tbl_shift = (r.st == crd_pkg::ST_RUN) ? crd_pkg::crd_shift_f(r.mode, r.iter + 4'h1)
    : crd_pkg::crd_shift_f(r.mode, 4'h0);

  crd_iter_table u_table
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .en(mod_clk_en),
    .mode(r.mode),
    .shift(tbl_shift),
    .tbl_q(tbl_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state: bus side, then kernel
  always_comb
  begin
    logic signed [crd_pkg::XY_W-1:0] xs;
    logic signed [crd_pkg::XY_W-1:0] ys;
    logic signed [crd_pkg::Z_W-1:0] e;
    logic d_pos;
    n = r;
    n.irq = 1'b0;
    // arithmetic shift drops low bits; accepted truncation error
    xs = $signed(r.x) >>> sh;
    ys = $signed(r.y) >>> sh;
    e = {tbl_q[crd_pkg::TBL_W-1], tbl_q};
    // vectoring drives y to zero, rotation drives z to zero
    d_pos = r.vec ? r.y[crd_pkg::XY_W-1] : !r.z[crd_pkg::Z_W-1];
    // read data captured in the setup cycle
    if (psel && !penable && !pwrite)
    begin
      n.rdata = 32'h0000_0000;
      if (crd_hit_f(paddr, crd_pkg::OFF_CTRL))
        n.rdata[5:0] = {r.xuns, r.keep, r.vec, r.mode, calc_busy};
      else if (crd_hit_f(paddr, crd_pkg::OFF_STAT))
        n.rdata[1:0] = {r.eoc, calc_busy};
      else if (crd_hit_f(paddr, crd_pkg::OFF_X))
        n.rdata[15:0] = x_view;
      else if (crd_hit_f(paddr, crd_pkg::OFF_Y))
        n.rdata[15:0] = r.y[23:8];
      else if (crd_hit_f(paddr, crd_pkg::OFF_Z))
        n.rdata[15:0] = r.z[19:4];
    end
    // writes land at the access edge; operands frozen while busy
    if (wr && !calc_busy)
    begin
      if (crd_hit_f(paddr, crd_pkg::OFF_CTRL))
      begin
        n.mode = pwdata[crd_pkg::CTRL_MODE_LO +: 2];
        n.vec = pwdata[crd_pkg::CTRL_VEC];
        n.keep = pwdata[crd_pkg::CTRL_KEEP];
        n.xuns = pwdata[crd_pkg::CTRL_XUNS];
      end
      if (crd_hit_f(paddr, crd_pkg::OFF_X))
        n.xin = pwdata[15:0];
      if (crd_hit_f(paddr, crd_pkg::OFF_Y))
        n.yin = pwdata[15:0];
      if (crd_hit_f(paddr, crd_pkg::OFF_Z))
        n.zin = pwdata[15:0];
    end
    // write one clears the end flag
    if (wr && crd_hit_f(paddr, crd_pkg::OFF_STAT) && pwdata[crd_pkg::STAT_EOC])
      n.eoc = 1'b0;
    // kernel sequencer; a stopped module clock freezes it in prep and run, but a go still moves it out of idle
    case (r.st)
      crd_pkg::ST_IDLE:
      begin
        if (start)
        begin
          n.st = crd_pkg::ST_PREP;
          n.iter = 4'h0;
          n.cnt = 6'h00;
          if (!pwdata[crd_pkg::CTRL_KEEP])
          begin
            // 16-bit operands sign-extended into the wide kernel
            n.x = {{2{r.xin[15]}}, r.xin, 8'h00};
            n.y = {{2{r.yin[15]}}, r.yin, 8'h00};
            n.z = {r.zin[15], r.zin, 4'h0};
          end
        end
      end
      crd_pkg::ST_PREP:
      begin
        if (mod_clk_en)
        begin
          n.st = crd_pkg::ST_RUN;
          n.cnt = r.cnt + 6'h01;
          // half turn: negate x and y, move the angle by pi with wrap-around
          if (half_turn)
          begin
            n.x = -r.x;
            n.y = -r.y;
            n.z = {{2{~r.z[19]}}, r.z[18:0]};
          end
        end
      end
      crd_pkg::ST_RUN:
      begin
        if (mod_clk_en)
        begin
          n.cnt = r.cnt + 6'h01;
          case (r.mode)
            crd_pkg::MODE_LIN: n.x = r.x;
            crd_pkg::MODE_HYP: n.x = d_pos ? r.x + ys : r.x - ys;
            default: n.x = d_pos ? r.x - ys : r.x + ys;
          endcase
          n.y = d_pos ? r.y + xs : r.y - xs;
          n.z = d_pos ? r.z - e : r.z + e;
          n.iter = r.iter + 4'h1;
          if (r.iter == 4'(crd_pkg::ITER_N - 1))
          begin
            n.st = crd_pkg::ST_IDLE;
            n.eoc = 1'b1; // set wins over a clear in the same cycle
            n.irq = 1'b1;
          end
        end
      end
      default: n.st = crd_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // single state register
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.st <= crd_pkg::ST_IDLE;
      r.mode <= crd_pkg::MODE_RST;
      r.xin <= crd_pkg::OPND_RST;
      r.yin <= crd_pkg::OPND_RST;
      r.zin <= crd_pkg::OPND_RST;
    end
    else
      r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  run_length_a: assert property (calc_busy |-> r.cnt <= 6'(crd_pkg::CALC_CYCLES))
    else $error("calculation runs too long");
  done_flag_a: assert property ($fell(calc_busy) |-> r.eoc && calc_done_irq)
    else $error("end flag or request missing at completion");
  irq_cause_a: assert property (
    calc_done_irq |-> $past(r.st) == crd_pkg::ST_RUN && !calc_busy)
    else $error("request without completion");
  go_ignore_a: assert property ((calc_busy && wr) |=> $stable(r.mode) && $stable(r.xin))
    else $error("write took effect while busy");
  gate_freeze_a: assert property (
    (calc_busy && !mod_clk_en) |=> $stable(r.x) && $stable(r.iter))
    else $error("kernel moved with clock gated");
  keep_hold_a: assert property (
    (start && pwdata[crd_pkg::CTRL_KEEP]) |=> $stable(r.x) && $stable(r.z))
    else $error("kernel reloaded with keep set");
  half_turn_a: assert property (
    (r.st == crd_pkg::ST_PREP && mod_clk_en && half_turn) |=> r.x == -$past(r.x))
    else $error("outer quadrant operand not folded");
  load_ext_a: assert property ((start && !pwdata[crd_pkg::CTRL_KEEP]) |=>
    r.x[23:8] == $past(r.xin) && r.x[25:24] == {2{$past(r.xin[15])}})
    else $error("x operand not sign-extended into kernel");
  uns_view_a: assert property ((r.xuns && r.x[crd_pkg::XY_W-1]) |-> x_view == 16'h0000)
    else $error("unsigned x view shows a negative value");
  err_answer_a: assert property ((acc && !mapped) |-> pslverr && pready)
    else $error("unmapped access not flagged");
  iter_count_a: assert property ($rose(calc_busy) ##1 mod_clk_en[*8] |-> r.iter == 4'h7)
    else $error("iteration count off");

  rot_done_c: cover property ($fell(calc_busy) && !r.vec && r.mode == crd_pkg::MODE_CIRC);
  vec_done_c: cover property ($fell(calc_busy) && r.vec);
  keep_go_c: cover property (start && pwdata[crd_pkg::CTRL_KEEP]);
  fold_c: cover property (r.st == crd_pkg::ST_PREP && mod_clk_en && half_turn);
  busy_go_c: cover property (calc_busy && wr && pwdata[crd_pkg::CTRL_GO]);
endmodule : crd_core
`default_nettype wire

// *** rtl/crd_iter_table.sv ***
// iteration table: arctangent, hyperbolic arctangent and emulated linear steps
`default_nettype none
module crd_iter_table
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // lookup
  input wire logic en,
  input wire logic [1:0] mode,
  input wire logic [3:0] shift,
  output logic [crd_pkg::TBL_W-1:0] tbl_q
);
  typedef struct packed {
    logic [crd_pkg::TBL_W-1:0] q;
  } crd_tbl_st_t;

  // angles scaled so that 2^19 stands for pi
  localparam logic [19:0] ATAN_T [16] = '{
    20'h20000, 20'h12E41, 20'h09FB4, 20'h05111, 20'h028B1, 20'h0145D, 20'h00A2F,
    20'h00518, 20'h0028C, 20'h00146, 20'h000A3, 20'h00051, 20'h00029, 20'h00014,
    20'h0000A, 20'h00005};
  localparam logic [19:0] ATANH_T [16] = '{
    20'h00000, 20'h16619, 20'h0A681, 20'h051EA, 20'h028D1, 20'h01461, 20'h00A30,
    20'h00518, 20'h0028C, 20'h00146, 20'h000A3, 20'h00051, 20'h00029, 20'h00014,
    20'h0000A, 20'h00005};

  crd_tbl_st_t r, n;

  ////////////////////////////////////////////////////////////////////////////////
  // entry select; linear steps are shifted, not stored, to save area
  always_comb
  begin
    n = r;
    if (en)
    begin
      case (mode)
        crd_pkg::MODE_LIN: n.q = crd_pkg::LIN_ONE >> shift;
        crd_pkg::MODE_HYP: n.q = ATANH_T[shift];
        default: n.q = ATAN_T[shift];
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      r <= '0;
    else
      r <= n;
  end

  assign tbl_q = r.q;

  lin_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (en && mode == crd_pkg::MODE_LIN) |=> tbl_q == (crd_pkg::LIN_ONE >> $past(shift)))
    else $error("linear step value wrong");
endmodule : crd_iter_table
`default_nettype wire

// *** rtl/crd_pkg.sv ***
// shared constants, types and decode helpers of the cordic coprocessor
`default_nettype none
package crd_pkg;
  // kernel and data widths
  localparam int DATA_W = 16;
  localparam int XY_W = 26;
  localparam int Z_W = 21;
  localparam int TBL_W = 20;
  localparam int ITER_N = 16;
  // operand placement inside the kernel
  localparam int XY_FRAC = 8;
  localparam int Z_FRAC = 4;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_X = 8'h08;
  localparam logic [7:0] OFF_Y = 8'h0C;
  localparam logic [7:0] OFF_Z = 8'h10;
  // control fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_VEC = 3;
  localparam int CTRL_KEEP = 4;
  localparam int CTRL_XUNS = 5;
  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_EOC = 1;
  // function codes
  localparam logic [1:0] MODE_CIRC = 2'h0;
  localparam logic [1:0] MODE_LIN = 2'h1;
  localparam logic [1:0] MODE_HYP = 2'h2;
  // reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [15:0] OPND_RST = 16'h0000;
  // linear step 1.0 in 1.15 form
  localparam logic [TBL_W-1:0] LIN_ONE = 20'h08000;
  // go edge to end flag, in enabled clock edges
  localparam int CALC_CYCLES = ITER_N + 1;
  localparam int CALC_LIMIT = 41;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_PREP = 2'b01,
    ST_RUN = 2'b11
  } crd_state_t;

  // hyperbolic steps start at 1 and repeat step 4 to converge
  function automatic logic [3:0] crd_shift_f(input logic [1:0] mode, input logic [3:0] iter);
    if (mode == MODE_HYP && iter < 4'h4)
      crd_shift_f = iter + 4'h1;
    else
      crd_shift_f = iter;
  endfunction : crd_shift_f
endpackage : crd_pkg
`default_nettype wire

// *** test/cordic_coprocessor_tb.sv ***
// self-checking bench of the cordic coprocessor core
`default_nettype none
module cordic_coprocessor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam real PI = 3.14159265358979;
  logic ref_clk, sys_rst, mod_clk_en, psel, penable, pwrite, pready, pslverr;
  logic calc_done_irq, calc_busy, e, ok;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int fails, tests_run;
  real kc, kh;

  crd_core #(.ADDR_W(8)) crd_core_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .mod_clk_en(mod_clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .calc_done_irq(calc_done_irq), .calc_busy(calc_busy));
  crd_apb_cpu crd_apb_cpu_inst (.ref_clk(ref_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // 125 mhz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////
  // compare on the 16-bit view with tolerance; zero tolerance compares all 32 bits
  task automatic check(input logic [31:0] s, input logic [31:0] x, input int t);
    int d;
    d = int'($signed(s[15:0] - x[15:0]));
    tests_run++;
    if (t == 0 ? s !== x : ((^s) === 1'bx || d > t || d < -t))
    begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : check

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic tmo;
    fails++;
    wrap_up();
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    crd_apb_cpu_inst.xfer(1'b1, a, d, q, e, ok);
    if (ok !== 1'b1)
      tmo();
  endtask : wr

  task automatic rd(input logic [7:0] a);
    crd_apb_cpu_inst.xfer(1'b0, a, 32'h00000000, q, e, ok);
    if (ok !== 1'b1)
      tmo();
  endtask : rd

  function automatic int rs(input int r);
    return int'($urandom % (2 * r + 1)) - r;
  endfunction : rs

  // reference results in view units; gains are not compensated
  function automatic void ref_calc(input int m, v, x, y, z, output int ex, ey, ez);
    real t;
    t = z * PI / 32768.0;
    if (m == 1)
    begin
      ex = x;
      ey = v ? 0 : int'(y + x * z / 2048.0);
      ez = v ? int'(z + y * 2048.0 / x) : 0;
    end
    else if (m == 2)
    begin
      ex = v ? int'(kh * $sqrt(x * x - y * y)) : int'(kh * (x * $cosh(t) + y * $sinh(t)));
      ey = v ? 0 : int'(kh * (y * $cosh(t) + x * $sinh(t)));
      ez = v ? int'(z + $atanh(1.0 * y / x) * 32768.0 / PI) : 0;
    end
    else
    begin
      ex = v ? int'(kc * $sqrt(1.0 * x * x + y * y)) : int'(kc * (x * $cos(t) - y * $sin(t)));
      ey = v ? 0 : int'(kc * (y * $cos(t) + x * $sin(t)));
      ez = v ? int'(z + $atan2(y, x) * 32768.0 / PI) : 0;
    end
  endfunction : ref_calc

  // wait for completion, stalling the module clock for gl edges when asked
  task automatic fin(input int gl, output int n);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (gl > 0 && n == 2)
        mod_clk_en <= 1'b0;
      if (gl > 0 && n == 2 + gl)
        mod_clk_en <= 1'b1;
      #1;
    end
    while (calc_done_irq !== 1'b1 && n < 60);
    if (n >= 60)
      tmo();
  endtask : fin

  task automatic go(input int m, v, k, u, gl);
    int n;
    wr(crd_pkg::OFF_CTRL, {26'h0, u[0], k[0], v[0], m[1:0], 1'b1});
    #1;
    check(calc_busy, 32'h1, 0);
    fin(gl, n);
    check(n, 17 + gl, 0);
    check(calc_busy, 32'h0, 0);
    @(posedge ref_clk);
    #1;
    check(calc_done_irq, 32'h0, 0);
  endtask : go

  task automatic res(input int ex, ey, ez, t);
    rd(crd_pkg::OFF_X);
    check(q, ex, t);
    rd(crd_pkg::OFF_Y);
    check(q, ey, t);
    rd(crd_pkg::OFF_Z);
    check(q, ez, t);
  endtask : res

  task automatic calc(input int m, v, u, x, y, z);
    int ex, ey, ez;
    wr(crd_pkg::OFF_X, {16'h0000, x[15:0]});
    wr(crd_pkg::OFF_Y, {16'h0000, y[15:0]});
    wr(crd_pkg::OFF_Z, {16'h0000, z[15:0]});
    go(m, v, 0, u, 0);
    ref_calc(m, v, x, y, z, ex, ey, ez);
    if (u && ex < 0)
      ex = 0;
    if (u && ex > 65535)
      ex = 65535;
    res(ex, ey, ez, m == 1 ? 6 : 12);
    rd(crd_pkg::OFF_STAT);
    check(q, 32'h2, 0);
    wr(crd_pkg::OFF_STAT, 32'h2);
  endtask : calc
  ////////////////////////////////////////
  // main sequence
  initial
  begin
    int x, y, z, m, v, n;
    fails = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    mod_clk_en = 1'b1;
    kc = 1.0;
    kh = $sqrt(1.0 - 2.0 ** -8); // step 4 runs twice
    for (int i = 0; i < 16; i++)
    begin
      kc = kc * $sqrt(1.0 + 2.0 ** (-2 * i));
      if (i > 0)
        kh = kh * $sqrt(1.0 - 2.0 ** (-2 * i));
    end
    void'($urandom(32'h6637));
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 20; a += 4)
    begin
      rd(a[7:0]);
      check(q, 32'h0, 0);
    end
    rd(8'h14);
    check(q, 32'h0, 0);
    check(e, 32'h1, 0);
    $display("test reset and unmapped done");
    calc(0, 1, 0, -12000, 0, 0);
    calc(0, 0, 0, 10000, 0, -32768);
    calc(0, 1, 1, 30000, 0, 0);
    calc(0, 1, 1, 30000, 30000, 0);
    calc(1, 0, 1, -5, 100, 0);
    $display("test corners done");
    calc(0, 1, 0, 6000, 3000, 0);
    rd(crd_pkg::OFF_X);
    x = int'($signed(q[15:0]));
    rd(crd_pkg::OFF_Z);
    z = int'($signed(q[15:0]));
    wr(crd_pkg::OFF_X, 32'h1);
    wr(crd_pkg::OFF_Y, 32'h1);
    go(0, 1, 1, 0, 0);
    res(int'(kc * x), 0, z, 12);
    $display("test keep done");
    wr(crd_pkg::OFF_X, 32'h3);
    wr(crd_pkg::OFF_Y, 32'h0);
    wr(crd_pkg::OFF_Z, 32'h800);
    go(1, 0, 0, 0, 4);
    res(3, 3, 0, 6);
    $display("test clock gate done");
    wr(crd_pkg::OFF_STAT, 32'h2);
    wr(crd_pkg::OFF_X, 32'h64);
    wr(crd_pkg::OFF_Z, 32'h400);
    wr(crd_pkg::OFF_CTRL, 32'h3);
    wr(crd_pkg::OFF_X, 32'h7);
    wr(crd_pkg::OFF_CTRL, 32'h5);
    rd(crd_pkg::OFF_STAT);
    check(q, 32'h1, 0);
    fin(0, n);
    check(n, 8, 0);
    wr(crd_pkg::OFF_STAT, 32'h2);
    repeat (25) @(posedge ref_clk);
    rd(crd_pkg::OFF_STAT);
    check(q, 32'h0, 0);
    res(100, 50, 0, 6);
    $display("test busy refusal done");
    // random mix of all function codes, code 3 behaves as circular
    for (int i = 0; i < 40; i++)
    begin
      m = $urandom % 4;
      v = $urandom % 2;
      x = m == 1 ? (v ? 2000 + rs(1000) : rs(2000)) : m == 2 ? 8000 + rs(4000) : rs(12000);
      y = m == 1 ? (v ? rs(x) : rs(8000)) : m == 2 ? (v ? rs(x * 7 / 10) : 0) : rs(12000);
      z = v ? rs(2000) : m == 1 ? rs(3900) : m == 2 ? rs(10000) : rs(32767);
      calc(m, v, 0, x, y, z);
    end
    $display("test random done");
    wrap_up();
  end
endmodule : cordic_coprocessor_tb
`default_nettype wire

// *** test/crd_apb_cpu.sv ***
// processor-side apb master model issuing register transfers to the core
`default_nettype none
module crd_apb_cpu
(
  // clock
  input wire logic ref_clk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  ////////////////////////////////////////
  // one transfer; an idle edge first, so no signal is assigned twice in one step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e, output logic ok);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    ok = (n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // stale data must not look valid
  endtask : xfer
endmodule : crd_apb_cpu
`default_nettype wire
